// ### hdl/psc_cfg.svh
// Purpose: Constants for the packed string compare datapath
// Assumes: Included by bare name ahead of the package and each module
// Notes: Control byte field positions, codes and widths live here
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// Operand and element geometry
`define PSC_VEC_W 128
`define PSC_NB 16
`define PSC_NW 8
`define PSC_LEN_W 5

// Control byte fields
`define PSC_IMM_WORD 0
`define PSC_IMM_SGN 1
`define PSC_IMM_AGG_LO 2
`define PSC_IMM_AGG_HI 3
`define PSC_IMM_NEG 4
`define PSC_IMM_MSKD 5
`define PSC_IMM_OUT 6

// Aggregation codes
`define PSC_AGG_ANY 2'h0
`define PSC_AGG_RANGE 2'h1
`define PSC_AGG_EACH 2'h2
`define PSC_AGG_ORD 2'h3

// Feature report word, the support bit is set from reset onward
`define PSC_FEAT_BIT 20
`define PSC_FEAT_VAL 32'h0010_0000

`endif

// ### hdl/psc_pkg.sv
// Purpose: Types and shared helpers of the packed string compare datapath
// Assumes: Nothing beyond the constants header
// Notes: Element extraction is shared by the matrix and the top
`include "psc_cfg.svh"
package psc_pkg;

    // Operation selector, one-hot
    typedef enum logic [4:0] {
        PSC_EXPLICIT_LEN_COMPARE_INDEX = 5'h01,
        PSC_EXPLICIT_LEN_COMPARE_MASK = 5'h02,
        PSC_NULL_TERM_COMPARE_INDEX = 5'h04,
        PSC_NULL_TERM_COMPARE_MASK = 5'h08,
        PSC_QUAD_GREATER_COMPARE = 5'h10
    } psc_op_e;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        PSC_ST_IDLE = 3'h1,
        PSC_ST_CALC = 3'h2,
        PSC_ST_OUT = 3'h4
    } psc_state_e;

    // One issued operation with its operands
    typedef struct packed {
        psc_op_e op;
        logic [7:0] imm;
        logic b_from_mem;
        logic [31:0] acc_len;
        logic [31:0] data_len;
        logic [`PSC_VEC_W-1:0] src_a;
        logic [`PSC_VEC_W-1:0] src_b;
    } psc_cmd_s;

    // Pair matrix, bit i*16+j pairs element i of a with element j of b
    typedef logic [`PSC_NB*`PSC_NB-1:0] psc_mat_t;

    // Element idx of v, extended to 17 bits by the signedness flag
    function automatic logic [16:0] psc_elem(input logic [`PSC_VEC_W-1:0] v,
                                             input logic word, input logic sgn,
                                             input logic [3:0] idx);
        logic [`PSC_VEC_W-1:0] s;
        s = word ? (v >> {idx[2:0], 4'h0}) : (v >> {idx, 3'h0});
        if (word) begin
            psc_elem = {sgn & s[15], s[15:0]};
        end else begin
            psc_elem = {{9{sgn & s[7]}}, s[7:0]};
        end
    endfunction : psc_elem

endpackage : psc_pkg

// ### hdl/psc_matrix.sv
// Purpose: All-pairs element comparator for two 128-bit fragments
// Assumes: Purely combinational, read one cycle after operands settle
// Notes: In word mode only the low 8x8 corner of the matrix is meaningful
`include "psc_cfg.svh"
module psc_matrix import psc_pkg::*; (
    input wire logic [`PSC_VEC_W-1:0] a_i,
    input wire logic [`PSC_VEC_W-1:0] b_i,
    input wire logic word_i,
    input wire logic sgn_i,
    output psc_mat_t eq_o,
    output psc_mat_t ge_o,
    output psc_mat_t le_o
);

    ////////////////////////////////////////////////////////////////////
    // Every a element against every b element, 256 pairs at most
    always_comb begin
        logic signed [16:0] ea;
        logic signed [16:0] eb;
        ea = '0;
        eb = '0;
        eq_o = '0;
        ge_o = '0;
        le_o = '0;
        for (int i = 0; i < `PSC_NB; i++) begin
            for (int j = 0; j < `PSC_NB; j++) begin
                // Signed compare on 17 bits covers both signednesses [RULE2]
                ea = psc_elem(a_i, word_i, sgn_i, 4'(i));
                eb = psc_elem(b_i, word_i, sgn_i, 4'(j));
                eq_o[i*`PSC_NB+j] = (ea == eb); // [RULE4]
                ge_o[i*`PSC_NB+j] = (eb >= ea);
                le_o[i*`PSC_NB+j] = (eb <= ea);
            end
        end
    end

endmodule : psc_matrix

// ### hdl/psc_top.sv
// Purpose: Packed string compare and packed quad greater-than datapath
// Assumes: Core holds CMD_I valid with START_I, one operation in flight
// Notes: Fixed three-cycle spacing, commands while busy are dropped
// Behaviour
// RULE1 - Operands are sixteen bytes or eight words
// RULE2 - Byte or word, signed or unsigned
// RULE3 - Four comparison kinds over elements
// RULE4 - All pairs compared, up to 256
// RULE5 - Pair results aggregated, then programmably processed
// RULE6 - Mask as bits or full-width elements
// RULE7 - Index searched from lowest or highest end
// RULE8 - Index to count register, mask to vector zero
// RULE9 - Control byte steers format, mode, processing, output
// RULE10 - Explicit lengths from accumulator and data registers
// RULE11 - Implicit length ends at first null
// RULE12 - Memory operand never faults on alignment
// RULE13 - Operands from registers or register plus memory
// RULE14 - Signed 64-bit lane greater-than compare
// RULE15 - Support reported in feature bit 20
// RULE16 - Null means all-zero element at selected width
`include "psc_cfg.svh"
module psc_top import psc_pkg::*; (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic START_I,
    input psc_cmd_s CMD_I,
    output logic BUSY_O,
    output logic DONE_O,
    output logic IDX_WE_O,
    output logic [31:0] IDX_O,
    output logic VEC_WE_O,
    output logic [`PSC_VEC_W-1:0] VEC_O,
    output logic VEC_DST_ZERO_O,
    output logic ALIGN_FAULT_O,
    output logic [31:0] FEATURE_ECX_O
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Magnitude of a signed length, clamped to the element count
    function automatic logic [`PSC_LEN_W-1:0] psc_len_clamp(input logic [31:0] v,
                                                           input logic word);
        logic [31:0] mag;
        logic [`PSC_LEN_W-1:0] n;
        mag = v[31] ? (~v + 32'h1) : v;
        n = word ? `PSC_LEN_W'(`PSC_NW) : `PSC_LEN_W'(`PSC_NB);
        psc_len_clamp = (mag > 32'(n)) ? n : mag[`PSC_LEN_W-1:0];
    endfunction : psc_len_clamp

    // Position of the lowest null element, or the element count
    function automatic logic [`PSC_LEN_W-1:0] psc_null_len(input logic [`PSC_VEC_W-1:0] v,
                                                          input logic word);
        logic [`PSC_LEN_W-1:0] n;
        logic [`PSC_LEN_W-1:0] k;
        logic found;
        n = word ? `PSC_LEN_W'(`PSC_NW) : `PSC_LEN_W'(`PSC_NB);
        k = n;
        found = 1'b0;
        for (int i = 0; i < `PSC_NB; i++) begin
            // Zero at the selected width, sign extension does not matter [RULE16]
            if (`PSC_LEN_W'(i) < n && !found && psc_elem(v, word, 1'b0, 4'(i)) == 17'h0) begin
                k = `PSC_LEN_W'(i); // [RULE11]
                found = 1'b1;
            end
        end
        psc_null_len = k;
    endfunction : psc_null_len

    ////////////////////////////////////////////////////////////////////
    // State and captured operation
    psc_state_e state_reg; // Sequencer
    psc_state_e state_next;
    psc_cmd_s cmd_reg; // Operation in flight
    logic [`PSC_NB-1:0] res_reg; // Processed intermediate result
    logic [1:0] qgt_reg; // Lane results of the quad compare
    logic busy_reg;
    logic done_reg;
    logic idx_we_reg;
    logic [31:0] idx_reg;
    logic vec_we_reg;
    logic [`PSC_VEC_W-1:0] vec_reg;
    logic dst0_reg;
    logic fault_reg;
    logic [31:0] feat_reg;

    ////////////////////////////////////////////////////////////////////
    // Decode of the captured operation and its control byte
    wire logic take = START_I && (state_reg == PSC_ST_IDLE);
    wire logic [7:0] imm = cmd_reg.imm;
    wire logic is_word = imm[`PSC_IMM_WORD]; // [RULE9]
    wire logic is_sgn = imm[`PSC_IMM_SGN];
    wire logic [1:0] agg = imm[`PSC_IMM_AGG_HI:`PSC_IMM_AGG_LO];
    wire logic pol_neg = imm[`PSC_IMM_NEG];
    wire logic pol_msk = imm[`PSC_IMM_MSKD];
    wire logic out_sel = imm[`PSC_IMM_OUT];
    wire logic is_exp = (cmd_reg.op == PSC_EXPLICIT_LEN_COMPARE_INDEX) ||
                        (cmd_reg.op == PSC_EXPLICIT_LEN_COMPARE_MASK);
    wire logic is_idx = (cmd_reg.op == PSC_EXPLICIT_LEN_COMPARE_INDEX) ||
                        (cmd_reg.op == PSC_NULL_TERM_COMPARE_INDEX);
    wire logic is_qgt = (cmd_reg.op == PSC_QUAD_GREATER_COMPARE);
    // Element count, 16 bytes or 8 words
    wire logic [`PSC_LEN_W-1:0] n_el = is_word ? `PSC_LEN_W'(`PSC_NW) : `PSC_LEN_W'(`PSC_NB); // [RULE1]

    ////////////////////////////////////////////////////////////////////
    // Valid lengths of both operands
    // The memory flag only tells where b came from; no alignment check
    wire logic [`PSC_LEN_W-1:0] len_a = is_exp ? psc_len_clamp(cmd_reg.acc_len, is_word) :
                                        psc_null_len(cmd_reg.src_a, is_word); // [RULE10]
    wire logic [`PSC_LEN_W-1:0] len_b = is_exp ? psc_len_clamp(cmd_reg.data_len, is_word) :
                                        psc_null_len(cmd_reg.src_b, is_word); // [RULE11]
    logic [`PSC_NB-1:0] va; // Element of a below its length
    logic [`PSC_NB-1:0] vb;
    always_comb begin
        for (int i = 0; i < `PSC_NB; i++) begin
            va[i] = (`PSC_LEN_W'(i) < len_a);
            vb[i] = (`PSC_LEN_W'(i) < len_b);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pair matrix on the captured operands
    psc_mat_t eq_m;
    psc_mat_t ge_m;
    psc_mat_t le_m;
    psc_matrix u_matrix (
        .a_i(cmd_reg.src_a),
        .b_i(cmd_reg.src_b),
        .word_i(is_word),
        .sgn_i(is_sgn),
        .eq_o(eq_m),
        .ge_o(ge_m),
        .le_o(le_m)
    );

    ////////////////////////////////////////////////////////////////////
    // Aggregation of the pair matrix into one bit per b position
    logic [`PSC_NB-1:0] res1;
    logic [`PSC_NB-1:0] res2;
    always_comb begin
        logic hit;
        hit = 1'b0;
        res1 = '0;
        for (int j = 0; j < `PSC_NB; j++) begin
            hit = 1'b0;
            case (agg) // [RULE3]
                `PSC_AGG_ANY: begin
                    // Any a element equals b element j
                    for (int i = 0; i < `PSC_NB; i++) begin
                        hit = hit | (va[i] & vb[j] & eq_m[i*`PSC_NB+j]);
                    end
                end
                `PSC_AGG_RANGE: begin
                    // b element j inside any [low, high] pair of a
                    for (int k = 0; k < `PSC_NB / 2; k++) begin
                        hit = hit | (va[2*k] & va[2*k+1] & vb[j] &
                                     ge_m[(2*k)*`PSC_NB+j] & le_m[(2*k+1)*`PSC_NB+j]);
                    end
                end
                `PSC_AGG_EACH: begin
                    // Same position; two invalid elements count as equal
                    hit = (va[j] & vb[j]) ? eq_m[j*`PSC_NB+j] : ~(va[j] ^ vb[j]);
                end
                `PSC_AGG_ORD: begin
                    // Substring a starting at b position j; a running out matches
                    hit = 1'b1;
                    for (int k = 0; k < `PSC_NB; k++) begin
                        if (j + k < `PSC_NB) begin
                            hit = hit & (~va[k] | (vb[j+k] & eq_m[k*`PSC_NB+j+k]));
                        end else begin
                            hit = hit & ~va[k];
                        end
                    end
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            res1[j] = hit & (`PSC_LEN_W'(j) < n_el); // [RULE5]
        end
    end

    // Polarity: plain, inverted, or inverted over valid b elements only
    always_comb begin
        for (int j = 0; j < `PSC_NB; j++) begin
            if (!pol_neg) begin
                res2[j] = res1[j];
            end else if (pol_msk) begin
                res2[j] = vb[j] ? ~res1[j] : res1[j]; // [RULE5]
            end else begin
                res2[j] = ~res1[j] & (`PSC_LEN_W'(j) < n_el);
            end
        end
    end

    // Signed 64-bit lanes, a greater than b
    wire logic [1:0] qgt = {$signed(cmd_reg.src_a[127:64]) > $signed(cmd_reg.src_b[127:64]),
                            $signed(cmd_reg.src_a[63:0]) > $signed(cmd_reg.src_b[63:0])}; // [RULE14]

    ////////////////////////////////////////////////////////////////////
    // Output forming from the processed result
    logic [`PSC_LEN_W-1:0] idx_lo; // Lowest set position, else count
    logic [`PSC_LEN_W-1:0] idx_hi; // Highest set position, else count
    logic [`PSC_VEC_W-1:0] mask_exp;
    always_comb begin
        idx_lo = n_el;
        idx_hi = n_el;
        for (int j = `PSC_NB - 1; j >= 0; j--) begin
            if (res_reg[j]) begin
                idx_lo = `PSC_LEN_W'(j);
            end
        end
        for (int j = 0; j < `PSC_NB; j++) begin
            if (res_reg[j]) begin
                idx_hi = `PSC_LEN_W'(j);
            end
        end
    end
    always_comb begin
        mask_exp = '0;
        for (int j = 0; j < `PSC_NB; j++) begin
            if (is_word && j < `PSC_NW) begin
                mask_exp[j*16 +: 16] = {16{res_reg[j]}};
            end else if (!is_word) begin
                mask_exp[j*8 +: 8] = {8{res_reg[j]}};
            end
        end
    end
    wire logic [`PSC_LEN_W-1:0] idx_sel = out_sel ? idx_hi : idx_lo; // [RULE7]
    wire logic [`PSC_VEC_W-1:0] mask_sel = out_sel ? mask_exp :
                                           {{(`PSC_VEC_W-`PSC_NB){1'b0}}, res_reg}; // [RULE6]
    wire logic [`PSC_VEC_W-1:0] qgt_vec = {{64{qgt_reg[1]}}, {64{qgt_reg[0]}}};

    ////////////////////////////////////////////////////////////////////
    // Sequencer: take, compute, write back
    always_comb begin
        case (state_reg)
            PSC_ST_IDLE: state_next = take ? PSC_ST_CALC : PSC_ST_IDLE; // [RULE13]
            PSC_ST_CALC: state_next = PSC_ST_OUT;
            PSC_ST_OUT: state_next = PSC_ST_IDLE;
            default: state_next = PSC_ST_IDLE;
        endcase
    end
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= PSC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Capture operands on take; both register and memory sources accepted
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cmd_reg <= '0;
        end else if (take) begin
            cmd_reg <= CMD_I; // [RULE13]
        end
    end

    // Intermediate result and lane compare held for the write-back cycle
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            res_reg <= '0;
            qgt_reg <= '0;
        end else if (state_reg == PSC_ST_CALC) begin
            res_reg <= res2;
            qgt_reg <= qgt;
        end
    end

    // Write-back strobes, one cycle each
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            done_reg <= 1'b0;
            idx_we_reg <= 1'b0;
            vec_we_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == PSC_ST_OUT);
            idx_we_reg <= (state_reg == PSC_ST_OUT) && is_idx; // [RULE8]
            vec_we_reg <= (state_reg == PSC_ST_OUT) && !is_idx;
            busy_reg <= (state_next != PSC_ST_IDLE);
        end
    end

    // Result data; a mask always targets vector register zero
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            idx_reg <= '0;
            vec_reg <= '0;
            dst0_reg <= 1'b0;
        end else if (state_reg == PSC_ST_OUT) begin
            idx_reg <= is_idx ? {{(32-`PSC_LEN_W){1'b0}}, idx_sel} : idx_reg;
            vec_reg <= is_idx ? vec_reg : (is_qgt ? qgt_vec : mask_sel);
            dst0_reg <= !is_qgt && !is_idx; // [RULE8]
        end
    end

    // Alignment is never checked, so the fault flag stays low
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fault_reg <= 1'b0;
            feat_reg <= `PSC_FEAT_VAL;
        end else begin
            fault_reg <= 1'b0; // [RULE12]
            feat_reg <= `PSC_FEAT_VAL; // [RULE15]
        end
    end

    assign BUSY_O = busy_reg;
    assign DONE_O = done_reg;
    assign IDX_WE_O = idx_we_reg;
    assign IDX_O = idx_reg;
    assign VEC_WE_O = vec_we_reg;
    assign VEC_O = vec_reg;
    assign VEC_DST_ZERO_O = dst0_reg;
    assign ALIGN_FAULT_O = fault_reg;
    assign FEATURE_ECX_O = feat_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    // Done of the previous op may still stand at a back-to-back take
    a_done_latency: assert property (take |=> !DONE_O ##1 !DONE_O ##1 DONE_O) // [RULE5]
        else $error("done not three edges after take");
    a_busy_span: assert property (take |=> BUSY_O ##1 BUSY_O ##1 !BUSY_O) // [RULE13]
        else $error("busy window wrong");
    a_index_dest: assert property (DONE_O |-> (IDX_WE_O == is_idx) && (VEC_WE_O != is_idx)) // [RULE8]
        else $error("wrong write-back target");
    a_mask_zero: assert property (VEC_WE_O && !is_qgt |-> VEC_DST_ZERO_O) // [RULE8]
        else $error("mask not sent to vector register zero");
    a_mem_nofault: assert property (take && CMD_I.b_from_mem |-> ##3 DONE_O && !ALIGN_FAULT_O) // [RULE12]
        else $error("memory operand faulted or stalled");
    a_feature_bit: assert property (FEATURE_ECX_O[`PSC_FEAT_BIT] && $stable(FEATURE_ECX_O)) // [RULE15]
        else $error("feature bit missing");
    a_index_range: assert property (IDX_WE_O |-> IDX_O <= 32'(n_el)) // [RULE1]
        else $error("index beyond element count");
    a_bitmask_high: assert property (VEC_WE_O && !is_qgt && !out_sel |-> VEC_O[127:16] == '0) // [RULE6]
        else $error("bit mask spills over");
    a_index_lowest: assert property (IDX_WE_O && !out_sel && IDX_O < 32'(n_el) |->
        res_reg[IDX_O[3:0]] && ((res_reg & ((16'h1 << IDX_O[3:0]) - 16'h1)) == '0)) // [RULE7]
        else $error("index not lowest set position");
    a_quad_lane: assert property (take && CMD_I.op == PSC_QUAD_GREATER_COMPARE |-> ##3
        VEC_O[63:0] == {64{$signed(cmd_reg.src_a[63:0]) > $signed(cmd_reg.src_b[63:0])}}) // [RULE14]
        else $error("quad lane compare wrong");
    a_busy_drop: assert property (START_I && busy_reg |=> $stable(cmd_reg)) // [RULE13]
        else $error("command taken while busy");

    c_exp_index: cover property (IDX_WE_O && is_exp && IDX_O < 32'(n_el));
    c_null_mask: cover property (VEC_WE_O && !is_exp && !is_qgt && out_sel);
    c_quad: cover property (VEC_WE_O && is_qgt && qgt_reg == 2'h1);
    c_ordered: cover property (DONE_O && agg == `PSC_AGG_ORD && res_reg != '0);

endmodule : psc_top

// ### test/psc_core_model.sv
// Purpose: Core-side issue model that feeds the packed string compare datapath
// Assumes: The issue task is entered just after a falling clock edge
// Notes: Between requests the command bus shows the inverse of the last one
`include "psc_cfg.svh"
module psc_core_model import psc_pkg::*; (
    input wire logic clk_i,
    input wire logic done_i,
    input wire logic idx_we_i,
    input wire logic vec_we_i,
    input wire logic dst_zero_i,
    input wire logic fault_i,
    input wire logic [31:0] feat_i,
    input wire logic [31:0] idx_i,
    input wire logic [`PSC_VEC_W-1:0] vec_i,
    output logic start_o,
    output psc_cmd_s cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    // Quiet bus at time zero
    initial begin
        start_o = 1'b0;
        cmd_o = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One request; lat counts falling edges from the take edge to write-back
    task automatic issue(input psc_cmd_s c, output logic [31:0] idx,
            output logic [`PSC_VEC_W-1:0] vec, output logic [3:0] fl, output int lat);
        lat = 0;
        // Software issues nothing unless support is reported
        if (feat_i[`PSC_FEAT_BIT] !== 1'b1) begin
            return;
        end
        start_o = 1'b1;
        cmd_o = c;
        @(posedge clk_i);
        @(negedge clk_i);
        // Inverse after the take, so a late sample of the bus shows up
        // A stray strobe while busy must be dropped by the datapath
        start_o = 1'b1;
        cmd_o = psc_cmd_s'(~c);
        @(negedge clk_i);
        start_o = 1'b0;
        lat = 2;
        // Bounded wait, a lost write-back ends with lat at the ceiling
        while (done_i !== 1'b1 && lat < 8) begin
            @(negedge clk_i);
            lat++;
        end
        idx = idx_i;
        vec = vec_i;
        fl = {idx_we_i, vec_we_i, dst_zero_i, fault_i};
    endtask : issue
endmodule : psc_core_model

// ### test/test_packed_string_compare.sv
// Purpose: Self-checking bench of the packed string compare datapath
// Assumes: Inputs change at the falling edge; results read one edge later
// Notes: Issues run back to back, so each take after the first lands on the done edge
`include "psc_cfg.svh"
module test_packed_string_compare import psc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [`PSC_VEC_W-1:0] psc_tbv_t; // One fragment
    // Operands: b ends in 'a' past its length, so clamping shows
    localparam psc_tbv_t A_ANY = 128'h7878_7878_7878_7878_7878_7878_7878_6561;
    localparam psc_tbv_t B_ANY = 128'h6161_6161_6161_6161_6161_6161_6579_6178;
    localparam psc_tbv_t A_NUL = 128'h7878_7878_7878_7878_7878_7878_7800_6561;
    localparam psc_tbv_t B_NUL = 128'h6161_6161_6161_6161_6161_0061_6579_6178;
    // Word halves with a zero low byte must not end the string
    localparam psc_tbv_t A_EACH = 128'h3333_2222_1111_0000_4400_cccc_bbbb_aaaa;
    localparam psc_tbv_t B_EACH = 128'h5555_6666_7777_0000_5500_cccc_bbbb_aaaa;
    logic clk, rst, start, busy, done, iwe, vwe, dst0, fault;
    psc_cmd_s cmd;
    logic [31:0] idx, feat;
    psc_tbv_t vec;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    psc_top u_psc_top (.SYS_CLK_I(clk), .RST_I(rst), .START_I(start), .CMD_I(cmd),
        .BUSY_O(busy), .DONE_O(done), .IDX_WE_O(iwe), .IDX_O(idx), .VEC_WE_O(vwe),
        .VEC_O(vec), .VEC_DST_ZERO_O(dst0), .ALIGN_FAULT_O(fault), .FEATURE_ECX_O(feat));

    psc_core_model u_psc_core_model (.clk_i(clk), .done_i(done), .idx_we_i(iwe),
        .vec_we_i(vwe), .dst_zero_i(dst0), .fault_i(fault), .feat_i(feat), .idx_i(idx),
        .vec_i(vec), .start_o(start), .cmd_o(cmd));

    ////////////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, a normal run needs about 50 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            $display("ERROR at %0t: timeout", $time);
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input psc_tbv_t seen, input psc_tbv_t exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Issue one op and judge latency, strobes and result
    task automatic run(input psc_op_e op, input logic [7:0] imm, input logic mem,
            input logic [31:0] al, input logic [31:0] dl, input psc_tbv_t a,
            input psc_tbv_t b, input psc_tbv_t exp);
        psc_cmd_s c;
        logic [31:0] i;
        psc_tbv_t v;
        logic [3:0] fl;
        logic ix;
        int lat;
        ix = (op == PSC_EXPLICIT_LEN_COMPARE_INDEX) || (op == PSC_NULL_TERM_COMPARE_INDEX);
        c = '{op, imm, mem, al, dl, a, b};
        u_psc_core_model.issue(c, i, v, fl, lat);
        chk(psc_tbv_t'(lat), 128'h3, "latency");
        chk(psc_tbv_t'(fl), psc_tbv_t'({ix, ~ix, ~ix & (op != PSC_QUAD_GREATER_COMPARE),
            1'b0}), "strobes");
        chk(ix ? psc_tbv_t'(i) : v, exp, "result");
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, support bit visible even while in reset
    task automatic t_reset();
        chk(psc_tbv_t'(feat), 128'h10_0000, "feature word");
        chk(psc_tbv_t'({busy, done, iwe, vwe, dst0, fault}), 128'h0, "reset strobes");
        chk(vec | psc_tbv_t'(idx), 128'h0, "reset results");
        $display("t_reset done");
    endtask : t_reset

    // Equal-any, explicit lengths, both index ends, both mask forms
    task automatic t_any();
        run(PSC_EXPLICIT_LEN_COMPARE_INDEX, 8'h00, 1'b0, 32'h2, 32'h5, A_ANY, B_ANY,
            128'h1);
        run(PSC_EXPLICIT_LEN_COMPARE_INDEX, 8'h40, 1'b1, 32'hffff_fffe, 32'h5, A_ANY,
            B_ANY, 128'h4);
        run(PSC_EXPLICIT_LEN_COMPARE_MASK, 8'h00, 1'b0, 32'h2, 32'h5, A_ANY, B_ANY,
            128'h1a);
        run(PSC_EXPLICIT_LEN_COMPARE_MASK, 8'h40, 1'b0, 32'h2, 32'h5, A_ANY, B_ANY,
            128'hff_ff00_ff00);
        $display("t_any done");
    endtask : t_any

    // Null-terminated forms, lengths on the bus must be ignored
    task automatic t_null();
        run(PSC_NULL_TERM_COMPARE_INDEX, 8'h40, 1'b0, 32'h1, 32'h1, A_NUL, B_NUL,
            128'h4);
        run(PSC_NULL_TERM_COMPARE_MASK, 8'h00, 1'b1, 32'h1, 32'h1, A_NUL, B_NUL,
            128'h1a);
        $display("t_null done");
    endtask : t_null

    // Equal-each on words with plain, full and valid-only negation
    task automatic t_each();
        run(PSC_NULL_TERM_COMPARE_MASK, 8'h09, 1'b0, 32'h0, 32'h0, A_EACH, B_EACH,
            128'hf7);
        run(PSC_NULL_TERM_COMPARE_MASK, 8'h19, 1'b0, 32'h0, 32'h0, A_EACH, B_EACH,
            128'h08);
        run(PSC_NULL_TERM_COMPARE_MASK, 8'h39, 1'b0, 32'h0, 32'h0, A_EACH, B_EACH,
            128'hf8);
        $display("t_each done");
    endtask : t_each

    // Ranges signed and unsigned; empty result gives the element count
    task automatic t_ranges();
        run(PSC_EXPLICIT_LEN_COMPARE_MASK, 8'h04, 1'b0, 32'h2, 32'h3, 128'h1080,
            128'h05_9020, 128'h0);
        run(PSC_EXPLICIT_LEN_COMPARE_MASK, 8'h06, 1'b0, 32'h2, 32'h3, 128'h1080,
            128'h05_9020, 128'h6);
        run(PSC_EXPLICIT_LEN_COMPARE_INDEX, 8'h04, 1'b0, 32'h2, 32'h3, 128'h1080,
            128'h05_9020, 128'h10);
        $display("t_ranges done");
    endtask : t_ranges

    // Equal-ordered substring search over all pairs
    task automatic t_ordered();
        run(PSC_EXPLICIT_LEN_COMPARE_INDEX, 8'h4c, 1'b0, 32'h2, 32'h5, 128'h6261,
            128'h62_6162_6178, 128'h3);
        run(PSC_EXPLICIT_LEN_COMPARE_MASK, 8'h0c, 1'b0, 32'h2, 32'h5, 128'h6261,
            128'h62_6162_6178, 128'ha);
        $display("t_ordered done");
    endtask : t_ordered

    // Signed lane compare, memory source, sign boundaries
    task automatic t_quad();
        run(PSC_QUAD_GREATER_COMPARE, 8'hff, 1'b1, 32'h0, 32'h0,
            {64'h1, 64'hffff_ffff_ffff_ffff}, {64'hffff_ffff_ffff_ffff, 64'h1},
            {64'hffff_ffff_ffff_ffff, 64'h0});
        run(PSC_QUAD_GREATER_COMPARE, 8'h00, 1'b0, 32'h0, 32'h0,
            {64'h8000_0000_0000_0000, 64'h5}, {64'h7fff_ffff_ffff_ffff, 64'h3},
            {64'h0, 64'hffff_ffff_ffff_ffff});
        $display("t_quad done");
    endtask : t_quad

    ////////////////////////////////////////////////////////////////////////////////
    // Counts, verdict and end of run
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // Main sequence, reset released at a falling edge
    initial begin
        rst = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        rst = 1'b0;
        t_any();
        t_null();
        t_each();
        t_ranges();
        t_ordered();
        t_quad();
        summarize();
    end
endmodule : test_packed_string_compare
